//--- pabafm_pkg.sv
`default_nettype none
package pabafm_pkg;

  // pins per port and index of the first port b pin in the combined pin vector
  localparam int unsigned PORT_PINS    = 8;
  localparam int unsigned PIN_COUNT    = 16;
  localparam int unsigned PB_BASE      = 8;

  // port b pin positions
  localparam int unsigned PB_SS        = 0;
  localparam int unsigned PB_SCK       = 1;
  localparam int unsigned PB_MOSI      = 2;
  localparam int unsigned PB_MISO      = 3;
  localparam int unsigned PB_CMP2A     = 4;
  localparam int unsigned PB_CMP1A     = 5;
  localparam int unsigned PB_CMP1B     = 6;
  localparam int unsigned PB_CMP7      = 7;

  // values after reset
  localparam logic [7:0] RST_PIN_OUT   = 8'h00;
  localparam logic [7:0] RST_PIN_OE_N  = 8'hff;
  localparam logic [7:0] RST_PULLUP    = 8'h00;
  localparam logic [7:0] RST_PIN_IN    = 8'h00;
  localparam logic       RST_SPI_IN    = 1'h0;
  localparam logic       RST_SS_N      = 1'h1;

  // override bundle of one pin
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic dir_override_en;
    logic dir_override_val;
    logic value_override_en;
    logic value_override_val;
    logic toggle_override_en;
    logic input_enable_override_en;
    logic input_enable_override_val;
  } pabafm_pin_ovr_t;

  // port control register contents
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] out;
  } pabafm_port_ctl_t;

  // external memory interface request
  typedef struct packed {
    logic       ext_mem_enable;
    logic       address_phase_active;
    logic       write_strobe;
    logic [7:0] addr_lo;
    logic [7:0] data_out;
  } pabafm_xmem_t;

  // spi core control and outputs
  typedef struct packed {
    logic enable;
    logic master;
    logic slave_out;
    logic master_out;
    logic sck_out;
  } pabafm_spi_t;

  // timer compare outputs with their enables
  typedef struct packed {
    logic timer0_compare_a_en;
    logic timer0_compare_a_out;
    logic timer1_compare_c_en;
    logic timer1_compare_c_out;
    logic timer1_compare_b_en;
    logic timer1_compare_b_out;
    logic timer1_compare_a_en;
    logic timer1_compare_a_out;
    logic timer2_compare_a_en;
    logic timer2_compare_a_out;
  } pabafm_cmp_t;

endpackage
`default_nettype wire

//--- pabafm_top.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - address_phase_active marks the address portion of each external bus cycle.
// - port a pull-up override enabled by ext memory and (address phase or write), value 0.
// - ext memory forces port a output during address or write; address or data driven.
// - port b bit 7 carries timer0 compare a or timer1 compare c when direction set.
// - port b bit 6 carries timer1 compare b when direction set.
// - port b bit 5 carries timer1 compare a when direction set.
// - port b bit 4 carries timer2 compare a when direction set.
// - compare pins also carry the timers' pwm waveforms.
// - port b bits 3..0 carry miso, mosi, sck and slave select.
// - spi master forces bit 3 to input regardless of direction bit.
// - spi slave lets bit 3 direction follow its direction bit.
// - forced-input bit 3 keeps pull-up controlled by its output bit.
// - spi slave forces bit 2 to input regardless of direction bit.
// - spi master lets bit 2 direction follow its direction bit.
// - forced-input bit 2 keeps pull-up controlled by its output bit.
// - spi slave forces bit 1 input; master lets direction bit decide.
// - spi slave forces bit 0 input; slave active while select is low.
// - pull-up follows override when enabled, else on for dir/out/disable 0,1,0.
module pabafm_top #(
  parameter int unsigned PORT_WIDTH = 8
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // port control registers and global pull-up disable
  input  wire pabafm_pkg::pabafm_port_ctl_t porta_ctl,
  input  wire pabafm_pkg::pabafm_port_ctl_t portb_ctl,
  input  wire logic                       global_pullup_disable,
  // alternate function sources
  input  wire pabafm_pkg::pabafm_xmem_t   xmem,
  input  wire pabafm_pkg::pabafm_spi_t    spi,
  input  wire pabafm_pkg::pabafm_cmp_t    cmp,
  // port a pads
  input  wire logic [7:0]                 porta_pin_in,
  output logic      [7:0]                 porta_pin_out,
  output logic      [7:0]                 porta_pin_oe_n,
  output logic      [7:0]                 porta_pullup_en,
  // port b pads
  input  wire logic [7:0]                 portb_pin_in,
  output logic      [7:0]                 portb_pin_out,
  output logic      [7:0]                 portb_pin_oe_n,
  output logic      [7:0]                 portb_pullup_en,
  // pin readback to the port input registers
  output logic      [7:0]                 porta_in_sync,
  output logic      [7:0]                 portb_in_sync,
  // inputs to the alternate functions
  output logic      [7:0]                 xmem_read_data,
  output logic                            spi_master_in,
  output logic                            spi_slave_in,
  output logic                            spi_sck_in,
  output logic                            spi_ss_n_in
);

  // the pin maps below are written for eight-pin ports only
  if (PORT_WIDTH != pabafm_pkg::PORT_PINS) begin : g_width_check
    $error("pabafm_top serves eight-pin ports only");
  end

  pabafm_pkg::pabafm_pin_ovr_t ovr [pabafm_pkg::PIN_COUNT];
  logic [15:0] ddr_w;
  logic [15:0] port_w;
  logic [15:0] pad_in_w;
  logic [15:0] dir_w;
  logic [15:0] val_w;
  logic [15:0] pu_w;
  logic [15:0] ie_w;
  logic [15:0] pin_out_reg;
  logic [15:0] pin_oe_n_reg;
  logic [15:0] pullup_reg;
  logic [15:0] pin_in_reg;
  logic        addr_or_write;
  logic        spi_as_master;
  logic        spi_as_slave;
  logic [7:4]  cmp_en_w;
  logic [7:4]  cmp_val_w;

  // flat views of the two ports
  assign ddr_w    = {portb_ctl.dir, porta_ctl.dir};
  assign port_w   = {portb_ctl.out, porta_ctl.out};
  assign pad_in_w = {portb_pin_in, porta_pin_in};

  // bus cycle qualifiers and spi role decode
  assign addr_or_write = xmem.address_phase_active | xmem.write_strobe;
  assign spi_as_master = spi.enable & spi.master;
  assign spi_as_slave  = spi.enable & ~spi.master;

  // port a: multiplexed low address and data bus
  for (genvar n = 0; n < 8; n++) begin : g_porta
    assign ovr[n] = '{
      pullup_override_en:        xmem.ext_mem_enable & addr_or_write,
      pullup_override_val:       1'b0,
      dir_override_en:           xmem.ext_mem_enable,
      dir_override_val:          addr_or_write,
      value_override_en:         xmem.ext_mem_enable,
      value_override_val:        (xmem.addr_lo[n] & xmem.address_phase_active)
                                 | (xmem.data_out[n] & xmem.write_strobe),
      toggle_override_en:        1'b0,
      input_enable_override_en:  1'b0,
      input_enable_override_val: 1'b0
    };
  end

  // compare sources on port b 7..4; on bit 7 an enabled timer1 c output wins
  assign cmp_en_w[7]  = cmp.timer0_compare_a_en | cmp.timer1_compare_c_en;
  assign cmp_val_w[7] = cmp.timer1_compare_c_en ? cmp.timer1_compare_c_out
                                                : cmp.timer0_compare_a_out;
  assign cmp_en_w[6]  = cmp.timer1_compare_b_en;
  assign cmp_val_w[6] = cmp.timer1_compare_b_out;
  assign cmp_en_w[5]  = cmp.timer1_compare_a_en;
  assign cmp_val_w[5] = cmp.timer1_compare_a_out;
  assign cmp_en_w[4]  = cmp.timer2_compare_a_en;
  assign cmp_val_w[4] = cmp.timer2_compare_a_out;

  // port b 7..4: value only, direction stays with the direction bit
  for (genvar k = 4; k < 8; k++) begin : g_portb_cmp
    assign ovr[pabafm_pkg::PB_BASE + k] = '{
      pullup_override_en:        1'b0,
      pullup_override_val:       1'b0,
      dir_override_en:           1'b0,
      dir_override_val:          1'b0,
      value_override_en:         cmp_en_w[k],
      value_override_val:        cmp_val_w[k],
      toggle_override_en:        1'b0,
      input_enable_override_en:  1'b0,
      input_enable_override_val: 1'b0
    };
  end

  // miso: input as master, slave output steered by its direction bit
  assign ovr[pabafm_pkg::PB_BASE + pabafm_pkg::PB_MISO] = '{
    pullup_override_en:        spi_as_master,
    pullup_override_val:       portb_ctl.out[pabafm_pkg::PB_MISO] & ~global_pullup_disable,
    dir_override_en:           spi_as_master,
    dir_override_val:          1'b0,
    value_override_en:         spi_as_slave,
    value_override_val:        spi.slave_out,
    toggle_override_en:        1'b0,
    input_enable_override_en:  1'b0,
    input_enable_override_val: 1'b0
  };

  // mosi: input as slave, master output steered by its direction bit
  assign ovr[pabafm_pkg::PB_BASE + pabafm_pkg::PB_MOSI] = '{
    pullup_override_en:        spi_as_slave,
    pullup_override_val:       portb_ctl.out[pabafm_pkg::PB_MOSI] & ~global_pullup_disable,
    dir_override_en:           spi_as_slave,
    dir_override_val:          1'b0,
    value_override_en:         spi_as_master,
    value_override_val:        spi.master_out,
    toggle_override_en:        1'b0,
    input_enable_override_en:  1'b0,
    input_enable_override_val: 1'b0
  };

  // sck: input as slave, master clock steered by its direction bit
  assign ovr[pabafm_pkg::PB_BASE + pabafm_pkg::PB_SCK] = '{
    pullup_override_en:        spi_as_slave,
    pullup_override_val:       portb_ctl.out[pabafm_pkg::PB_SCK] & ~global_pullup_disable,
    dir_override_en:           spi_as_slave,
    dir_override_val:          1'b0,
    value_override_en:         spi_as_master,
    value_override_val:        spi.sck_out,
    toggle_override_en:        1'b0,
    input_enable_override_en:  1'b0,
    input_enable_override_val: 1'b0
  };

  // slave select: input as slave, plain port pin as master
  assign ovr[pabafm_pkg::PB_BASE + pabafm_pkg::PB_SS] = '{
    pullup_override_en:        spi_as_slave,
    pullup_override_val:       portb_ctl.out[pabafm_pkg::PB_SS] & ~global_pullup_disable,
    dir_override_en:           spi_as_slave,
    dir_override_val:          1'b0,
    value_override_en:         1'b0,
    value_override_val:        1'b0,
    toggle_override_en:        1'b0,
    input_enable_override_en:  1'b0,
    input_enable_override_val: 1'b0
  };

  // per-pin combination of overrides with the port registers
  for (genvar i = 0; i < 16; i++) begin : g_pin
    assign dir_w[i] = ovr[i].dir_override_en ? ovr[i].dir_override_val : ddr_w[i];
    assign val_w[i] = ovr[i].value_override_en ? ovr[i].value_override_val
                                               : (port_w[i] ^ ovr[i].toggle_override_en);
    assign pu_w[i]  = ovr[i].pullup_override_en ? ovr[i].pullup_override_val
                    : (~ddr_w[i] & port_w[i] & ~global_pullup_disable);
    assign ie_w[i]  = ovr[i].input_enable_override_en ? ovr[i].input_enable_override_val
                                                      : 1'b1;
  end

  // pad drive, enable and pull-up registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_out_reg  <= {pabafm_pkg::RST_PIN_OUT, pabafm_pkg::RST_PIN_OUT};
      pin_oe_n_reg <= {pabafm_pkg::RST_PIN_OE_N, pabafm_pkg::RST_PIN_OE_N};
      pullup_reg   <= {pabafm_pkg::RST_PULLUP, pabafm_pkg::RST_PULLUP};
    end else begin
      pin_out_reg  <= val_w;
      pin_oe_n_reg <= ~dir_w; // low while driving
      pullup_reg   <= pu_w;
    end
  end

  // pad input capture, gated by the digital input enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_in_reg <= {pabafm_pkg::RST_PIN_IN, pabafm_pkg::RST_PIN_IN};
    end else begin
      pin_in_reg <= pad_in_w & ie_w;
    end
  end

  // alternate function inputs taken straight from the pads
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      xmem_read_data <= pabafm_pkg::RST_PIN_IN;
      spi_master_in  <= pabafm_pkg::RST_SPI_IN;
      spi_slave_in   <= pabafm_pkg::RST_SPI_IN;
      spi_sck_in     <= pabafm_pkg::RST_SPI_IN;
      spi_ss_n_in    <= pabafm_pkg::RST_SS_N;
    end else begin
      xmem_read_data <= porta_pin_in;
      spi_master_in  <= portb_pin_in[pabafm_pkg::PB_MISO];
      spi_slave_in   <= portb_pin_in[pabafm_pkg::PB_MOSI];
      spi_sck_in     <= portb_pin_in[pabafm_pkg::PB_SCK];
      spi_ss_n_in    <= portb_pin_in[pabafm_pkg::PB_SS];
    end
  end

  // port views of the pin registers
  assign porta_pin_out   = pin_out_reg[7:0];
  assign portb_pin_out   = pin_out_reg[15:8];
  assign porta_pin_oe_n  = pin_oe_n_reg[7:0];
  assign portb_pin_oe_n  = pin_oe_n_reg[15:8];
  assign porta_pullup_en = pullup_reg[7:0];
  assign portb_pullup_en = pullup_reg[15:8];
  assign porta_in_sync   = pin_in_reg[7:0];
  assign portb_in_sync   = pin_in_reg[15:8];

endmodule // pabafm_top
`default_nettype wire

//--- pabafm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pabafm_chk #(
  parameter int unsigned PORT_WIDTH = 8
) (
  // clock and reset
  input wire logic                         sys_clk,
  input wire logic                         rst,
  // controls and alternate function sources
  input wire pabafm_pkg::pabafm_port_ctl_t porta_ctl,
  input wire pabafm_pkg::pabafm_port_ctl_t portb_ctl,
  input wire logic                         global_pullup_disable,
  input wire pabafm_pkg::pabafm_xmem_t     xmem,
  input wire pabafm_pkg::pabafm_spi_t      spi,
  input wire pabafm_pkg::pabafm_cmp_t      cmp,
  input wire logic [7:0]                   porta_pin_in,
  // pad drive and readback
  input wire logic [7:0]                   porta_pin_out,
  input wire logic [7:0]                   porta_pin_oe_n,
  input wire logic [7:0]                   porta_pullup_en,
  input wire logic [7:0]                   portb_pin_out,
  input wire logic [7:0]                   portb_pin_oe_n,
  input wire logic [7:0]                   portb_pullup_en,
  input wire logic [7:0]                   xmem_read_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic run_reg;
  // the release edge may still see reset, so checks start one edge later
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) run_reg <= 1'b0;
    else run_reg <= 1'b1;
  end
  // spi modes and external bus phases
  wire mst = run_reg & spi.enable & spi.master;
  wire slv = run_reg & spi.enable & ~spi.master;
  wire xon = run_reg & xmem.ext_mem_enable & (xmem.address_phase_active | xmem.write_strobe);
  sequence s_addr;
    run_reg && xmem.ext_mem_enable && xmem.address_phase_active && !xmem.write_strobe;
  endsequence
  sequence s_wr;
    run_reg && xmem.ext_mem_enable && xmem.write_strobe && !xmem.address_phase_active;
  endsequence
  sequence s_xcycle;
    s_addr ##1 s_wr;
  endsequence
  AST_PA_ADDR: assert property (s_addr |=> porta_pin_out == $past(xmem.addr_lo))
    else $error("address byte not on port a");
  AST_PA_CYCLE: assert property (s_xcycle |=>
    porta_pin_out == $past(xmem.data_out) && porta_pin_oe_n == 8'h00)
    else $error("write data not driven after address phase");
  AST_PA_DRIVE: assert property (xon |=> porta_pin_oe_n == 8'h00 && porta_pullup_en == 8'h00)
    else $error("port a not driven or pull-up left on");
  AST_PA_READ: assert property (run_reg |=> xmem_read_data == $past(porta_pin_in))
    else $error("read data does not follow port a pads");
  AST_PB7_C: assert property (run_reg && cmp.timer1_compare_c_en |=>
    portb_pin_out[7] == $past(cmp.timer1_compare_c_out))
    else $error("bit 7 compare c value wrong");
  AST_PB7_A: assert property (run_reg && cmp.timer0_compare_a_en && !cmp.timer1_compare_c_en
    |=> portb_pin_out[7] == $past(cmp.timer0_compare_a_out))
    else $error("bit 7 compare a value wrong");
  AST_PB6: assert property (run_reg && cmp.timer1_compare_b_en |=>
    portb_pin_out[6] == $past(cmp.timer1_compare_b_out))
    else $error("bit 6 compare value wrong");
  AST_PB_DIR: assert property (run_reg |=> portb_pin_oe_n[7:4] == ~$past(portb_ctl.dir[7:4]))
    else $error("compare pin direction wrong");
  AST_MISO_MST: assert property (mst |=> portb_pin_oe_n[3]
    && portb_pullup_en[3] == ($past(portb_ctl.out[3]) & !$past(global_pullup_disable)))
    else $error("master input pin not released");
  AST_SLV_IN: assert property (slv |=> portb_pin_oe_n[2:0] == 3'h7
    && portb_pin_oe_n[3] == !$past(portb_ctl.dir[3]))
    else $error("slave pin directions wrong");
  AST_MST_OUT: assert property (mst |=> portb_pin_out[2] == $past(spi.master_out)
    && portb_pin_out[1] == $past(spi.sck_out) && portb_pin_oe_n[2:1] == ~$past(portb_ctl.dir[2:1]))
    else $error("master outputs wrong");
  AST_PULL: assert property (run_reg && !xmem.ext_mem_enable |=> porta_pullup_en
    == (~$past(porta_ctl.dir) & $past(porta_ctl.out) & {8{!$past(global_pullup_disable)}}))
    else $error("port a pull-up wrong");
endmodule // pabafm_chk
bind pabafm_top pabafm_chk #(.PORT_WIDTH(PORT_WIDTH)) u_pabafm_chk (
  .sys_clk(sys_clk), .rst(rst), .porta_ctl(porta_ctl), .portb_ctl(portb_ctl),
  .global_pullup_disable(global_pullup_disable), .xmem(xmem), .spi(spi), .cmp(cmp),
  .porta_pin_in(porta_pin_in), .porta_pin_out(porta_pin_out), .porta_pin_oe_n(porta_pin_oe_n),
  .porta_pullup_en(porta_pullup_en), .portb_pin_out(portb_pin_out), .portb_pin_oe_n(portb_pin_oe_n),
  .portb_pullup_en(portb_pullup_en), .xmem_read_data(xmem_read_data));
`default_nettype wire

//--- pabafm_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
module pabafm_bus_peer (
  // clock
  input  wire logic        sys_clk,
  // pads of both ports, port a in the upper byte
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  input  wire logic [15:0] pullup_en,
  // what the memory device and spi peer put on released pads
  input  wire logic [15:0] drv_en,
  input  wire logic [15:0] drv_val,
  // resolved pad levels
  output logic      [15:0] pin_in
);
  logic [15:0] flt_reg = 16'h5a5a;
  // floating pads show a pattern that flips every cycle
  always @(posedge sys_clk) flt_reg <= ~flt_reg;
  // the block wins where it drives; the peer only drives released pads
  assign pin_in = (~pin_oe_n & pin_out)
                | (pin_oe_n & drv_en & drv_val)
                | (pin_oe_n & ~drv_en & pullup_en)
                | (pin_oe_n & ~drv_en & ~pullup_en & flt_reg);
endmodule // pabafm_bus_peer
`default_nettype wire

//--- pabafm_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module pabafm_top_test;
  // stimulus, staged values and pads
  logic                         sys_clk = 1'b0;
  logic                         rst = 1'b1;
  logic                         global_pullup_disable = 1'b0;
  logic                         p_c;
  pabafm_pkg::pabafm_port_ctl_t porta_ctl = '0, portb_ctl = '0, a_c, b_c;
  pabafm_pkg::pabafm_xmem_t     xmem = '0, x_c;
  pabafm_pkg::pabafm_spi_t      spi = '0, s_c;
  pabafm_pkg::pabafm_cmp_t      cmp = '0, c_c;
  logic [15:0]                  drv_en = '0, drv_val = '0, de_c, dv_c;
  wire logic [7:0]              porta_pin_in, portb_pin_in, porta_pin_out, porta_pin_oe_n, porta_pullup_en;
  wire logic [7:0]              portb_pin_out, portb_pin_oe_n, portb_pullup_en, porta_in_sync, portb_in_sync;
  wire logic [7:0]              xmem_read_data;
  wire logic                    spi_master_in, spi_slave_in, spi_sck_in, spi_ss_n_in;
  logic [7:0]                   e_ao, e_aoe, e_apu, e_bo, e_boe, e_bpu;
  logic [63:0]                  st = 64'h90d;
  logic [63:0]                  exp_q[$];
  logic [63:0]                  ex;
  int                           mismatches = 0;
  int                           n_tests = 0;

  pabafm_top #(.PORT_WIDTH(8)) u_pabafm_top (.sys_clk(sys_clk), .rst(rst), .porta_ctl(porta_ctl),
    .portb_ctl(portb_ctl), .global_pullup_disable(global_pullup_disable), .xmem(xmem), .spi(spi), .cmp(cmp),
    .porta_pin_in(porta_pin_in), .porta_pin_out(porta_pin_out), .porta_pin_oe_n(porta_pin_oe_n),
    .porta_pullup_en(porta_pullup_en), .portb_pin_in(portb_pin_in), .portb_pin_out(portb_pin_out),
    .portb_pin_oe_n(portb_pin_oe_n), .portb_pullup_en(portb_pullup_en), .porta_in_sync(porta_in_sync),
    .portb_in_sync(portb_in_sync), .xmem_read_data(xmem_read_data), .spi_master_in(spi_master_in),
    .spi_slave_in(spi_slave_in), .spi_sck_in(spi_sck_in), .spi_ss_n_in(spi_ss_n_in));
  pabafm_bus_peer u_pabafm_bus_peer (.sys_clk(sys_clk), .pin_out({porta_pin_out, portb_pin_out}),
    .pin_oe_n({porta_pin_oe_n, portb_pin_oe_n}), .pullup_en({porta_pullup_en, portb_pullup_en}),
    .drv_en(drv_en), .drv_val(drv_val), .pin_in({porta_pin_in, portb_pin_in}));

  // clock
  initial forever #12.5 sys_clk = ~sys_clk;

  // xorshift source, seed 2317
  function automatic logic [63:0] nx();
    st = st ^ (st << 13);
    st = st ^ (st >> 7);
    st = st ^ (st << 17);
    return st;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected pads from the inputs seen at this edge
  task automatic model();
    logic m, s, a, w, q;
    m = spi.enable & spi.master;
    s = spi.enable & ~spi.master;
    a = xmem.ext_mem_enable & xmem.address_phase_active;
    w = xmem.ext_mem_enable & xmem.write_strobe;
    q = ~global_pullup_disable;
    e_aoe = xmem.ext_mem_enable ? {8{~(a | w)}} : ~porta_ctl.dir;
    e_ao = xmem.ext_mem_enable ? (xmem.addr_lo & {8{a}} | xmem.data_out & {8{w}}) : porta_ctl.out;
    e_apu = (a | w) ? 8'h00 : ~porta_ctl.dir & porta_ctl.out & {8{q}};
    e_boe = ~portb_ctl.dir;
    e_bpu = ~portb_ctl.dir & portb_ctl.out & {8{q}};
    e_bo = portb_ctl.out;
    if (cmp.timer2_compare_a_en) e_bo[4] = cmp.timer2_compare_a_out;
    if (cmp.timer1_compare_a_en) e_bo[5] = cmp.timer1_compare_a_out;
    if (cmp.timer1_compare_b_en) e_bo[6] = cmp.timer1_compare_b_out;
    if (cmp.timer1_compare_c_en) e_bo[7] = cmp.timer1_compare_c_out;
    else if (cmp.timer0_compare_a_en) e_bo[7] = cmp.timer0_compare_a_out;
    if (m) begin
      e_boe[3] = 1'b1;
      e_bpu[3] = portb_ctl.out[3] & q;
      e_bo[2:1] = {spi.master_out, spi.sck_out};
    end
    if (s) begin
      e_boe[2:0] = 3'h7;
      e_bpu[2:0] = portb_ctl.out[2:0] & {3{q}};
      e_bo[3] = spi.slave_out;
    end
  endtask

  // n cycles of random inputs; mode 1 bus cycles, mode 2 spi with all port b directions set
  task automatic run(input int n, input int mode, input string name);
    logic [63:0] r;
    for (int i = 0; i < n; i++) begin
      r = nx();
      {a_c, b_c, de_c, dv_c} = r;
      r = nx();
      {x_c, s_c, c_c, p_c} = r[34:0];
      if (mode == 1) begin
        x_c.ext_mem_enable = 1'b1;
        x_c.address_phase_active = ~i[0];
        x_c.write_strobe = i[0];
      end
      if (mode == 2) begin
        s_c.enable = 1'b1;
        s_c.master = i[3];
        b_c.dir = 8'hff;
        de_c[0] = ~s_c.master;
        dv_c[0] = 1'b0;
      end
      @(posedge sys_clk);
      {porta_ctl, portb_ctl, xmem, spi, cmp} <= {a_c, b_c, x_c, s_c, c_c};
      {global_pullup_disable, drv_en, drv_val} <= {p_c, de_c, dv_c};
    end
    $display("test %s done", name);
  endtask

  // queue expectations at each edge, compare at the falling edge
  always @(posedge sys_clk) begin
    if (!rst) begin
      model();
      exp_q.push_back({e_ao, e_aoe, e_apu, e_bo, e_boe, e_bpu, porta_pin_in, portb_pin_in});
    end
  end
  always @(negedge sys_clk) begin
    if (rst) exp_q.delete();
    else if (exp_q.size() > 0) begin
      ex = exp_q.pop_front();
      chk(porta_pin_out, ex[63:56]);
      chk(porta_pin_oe_n, ex[55:48]);
      chk(porta_pullup_en, ex[47:40]);
      chk(portb_pin_out, ex[39:32]);
      chk(portb_pin_oe_n, ex[31:24]);
      chk(portb_pullup_en, ex[23:16]);
      chk(xmem_read_data, ex[15:8]);
      chk(porta_in_sync, ex[15:8]);
      chk(portb_in_sync, ex[7:0]);
      chk({4'h0, spi_master_in, spi_slave_in, spi_sck_in, spi_ss_n_in}, {4'h0, ex[3:0]});
    end
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    chk(porta_pin_oe_n, 8'hff);
    chk(portb_pin_oe_n, 8'hff);
    chk(portb_pullup_en, 8'h00);
    chk({7'h0, spi_ss_n_in}, 8'h01);
    $display("test reset done");
    rst <= 1'b0;
    run(2000, 0, "random");
    run(64, 1, "bus_cycles");
    run(64, 2, "spi_modes");
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    run(500, 0, "after_reset");
    repeat (2) @(posedge sys_clk);
    end_of_test();
  end

  // watchdog
  initial begin
    #125000;
    mismatches++;
    end_of_test();
  end
endmodule // pabafm_top_test
`default_nettype wire
